// >>> tb/tb_twm_top.sv
// self-checking bench for the waveform timer
`timescale 1ns/100ps
module tb_twm_top;
	import twm_pkg::*;
	localparam logic [7:0] REGS [5] = '{OFS_CONTROL_A, OFS_COUNTER,
		OFS_COMPARE, OFS_FLAGS, OFS_DIRECTION};
	localparam logic [2:0] TAPS [3] = '{CS_DIV1, CS_DIV8, CS_DIV64};
	localparam int         DIVS [3] = '{1, 8, 64};
	localparam logic [1:0] FCOM [4] = '{COM_CLEAR, COM_SET, COM_TOGGLE,
		COM_TOGGLE};
	localparam logic       FPIN [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	logic        aclk = 0, aresetn = 0, ce = 1;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp, resp, com;
	logic        ext_in = 0, ovf_ack = 0, cmp_ack = 0, win_clr = 0;
	logic        ovf_flag, cmp_flag, pin, pin_oe;
	int          high_cnt, mismatches = 0, num_checks = 0, cyc = 0;
	int          last_t, last_hc, last_gap, c, e, tol, hc;

	////////////////////////////////////////////////////////////////////
	// clock and free cycle count
	always #12.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	twm_top twm_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.external_count_input(ext_in), .overflow_ack(ovf_ack),
		.compare_ack(cmp_ack), .overflow_flag(ovf_flag),
		.compare_match_flag(cmp_flag), .compare_output_pin(pin),
		.compare_output_oe(pin_oe));
	twm_load twm_load_i (.aclk(aclk), .aresetn(aresetn),
		.compare_output_pin(pin), .compare_output_oe(pin_oe),
		.window_clr(win_clr), .high_cnt(high_cnt));

	////////////////////////////////////////////////////////////////////
	// comparison and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic give_up;
		mismatches++;
		$display("wrong value at %0t: wait ran out", $time);
		tally_and_finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// bus master; one idle edge at the end so valids never double-assign
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (n > 100)
				give_up;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && !awvalid && !wvalid));
		bready <= 1'b0;
		resp = bresp;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (n > 100)
				give_up;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && !arvalid));
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
		@(posedge aclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] d);
		axi_rd(a);
		check(rd, d);
		check(resp, RESP_OKAY);
	endtask

	// control byte built from its fields
	function automatic logic [7:0] ctl(input logic [1:0] m,
		input logic [1:0] cm, input logic [2:0] cs, input logic f);
		twm_ctrl_t v;
		v = '{f, m[0], cm, m[1], cs};
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////
	// flag waits: acknowledge the flag and restart the load's window
	task automatic wait_flag(input logic which);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (n > 20000)
				give_up;
		end while (!(which ? cmp_flag : ovf_flag));
		last_t = cyc;
		if (which)
			cmp_ack <= 1'b1;
		else
			ovf_ack <= 1'b1;
		win_clr <= 1'b1;
		@(posedge aclk);
		// window runs up to the flag edge; the clear edge opens the next
		last_hc = high_cnt;
		cmp_ack <= 1'b0;
		ovf_ack <= 1'b0;
		win_clr <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic span(input logic which);
		int t0;
		wait_flag(which);
		t0 = last_t;
		wait_flag(which);
		last_gap = last_t - t0;
	endtask

	task automatic ext_pulse;
		ext_in <= 1'b1;
		repeat (4) @(posedge aclk);
		ext_in <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(32'haf07a102));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++)
			rd_chk(REGS[i], 32'h0000_0000);
		axi_rd(8'h40);
		check(resp, RESP_DECERR);
		// forced compare, counter stopped, pin first left as input
		axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_SET, CS_STOP, 1'b1));
		repeat (2) @(posedge aclk);
		check(pin_oe, 1'b0);
		axi_wr(OFS_DIRECTION, 8'h01);
		for (int i = 0; i < 4; i++) begin
			axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, FCOM[i], CS_STOP, 1'b1));
			repeat (2) @(posedge aclk);
			check({pin_oe, pin}, {1'b1, FPIN[i]});
		end
		check(cmp_flag, 1'b0);
		rd_chk(OFS_CONTROL_A, ctl(WM_NORMAL, COM_TOGGLE, CS_STOP, 1'b0));
		axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_OFF, CS_STOP, 1'b0));
		repeat (2) @(posedge aclk);
		check(pin_oe, 1'b0);
		// overflow spacing for the div1, div8 and div64 prescale taps
		for (int i = 0; i < 3; i++) begin
			axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_OFF, TAPS[i], 1'b0));
			span(1'b0);
			check(last_gap, 256 * DIVS[i]);
		end
		// a low enable freezes the count for exactly its length
		axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_OFF, CS_DIV1, 1'b0));
		wait_flag(1'b0);
		hc = last_t;
		ce <= 1'b0;
		repeat (40) @(posedge aclk);
		ce <= 1'b1;
		wait_flag(1'b0);
		check(last_t - hc, 256 + 40);
		// flags cleared by writing ones while stopped
		axi_wr(OFS_CONTROL_A, 8'h00);
		check(cmp_flag, 1'b1);
		axi_wr(OFS_FLAGS, 8'h03);
		rd_chk(OFS_FLAGS, 32'h0000_0000);
		check({ovf_flag, cmp_flag}, 2'b00);
		// compare-clear mode: top is the compare value
		c = 2 + $urandom % 200;
		axi_wr(OFS_COMPARE, 8'(c));
		axi_wr(OFS_CONTROL_A, ctl(WM_CLEAR, COM_OFF, CS_DIV1, 1'b0));
		span(1'b1);
		check(last_gap, c + 1);
		// external edges, rising then falling
		axi_wr(OFS_CONTROL_A, 8'h00);
		axi_wr(OFS_COUNTER, 8'hFE);
		axi_wr(OFS_FLAGS, 8'h03);
		rd_chk(OFS_COUNTER, 32'h0000_00FE);
		axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_OFF, CS_EXT_RISE, 1'b0));
		repeat (2) ext_pulse;
		rd_chk(OFS_COUNTER, 32'h0000_0000);
		check(ovf_flag, 1'b1);
		axi_wr(OFS_CONTROL_A, ctl(WM_NORMAL, COM_OFF, CS_EXT_FALL, 1'b0));
		ext_pulse;
		rd_chk(OFS_COUNTER, 32'h0000_0001);
		// counter written onto the compare value: next tick has no match
		axi_wr(OFS_COMPARE, 8'h05);
		axi_wr(OFS_COUNTER, 8'h05);
		ext_pulse;
		check(cmp_flag, 1'b0);
		rd_chk(OFS_COUNTER, 32'h0000_0006);
		// fast pwm toggle: half duty over two overflow windows
		axi_wr(OFS_COMPARE, 8'($urandom));
		axi_wr(OFS_CONTROL_A, ctl(WM_FAST, COM_TOGGLE, CS_DIV1, 1'b0));
		wait_flag(1'b0);
		span(1'b0);
		check(last_gap, 256);
		hc = last_hc;
		wait_flag(1'b0);
		check(hc + last_hc, 256);
		// fast non-inverting: set at the wrap, cleared on the match
		c = $urandom % 256;
		axi_wr(OFS_COMPARE, 8'(c));
		axi_wr(OFS_CONTROL_A, ctl(WM_FAST, COM_CLEAR, CS_DIV1, 1'b0));
		wait_flag(1'b0);
		span(1'b0);
		check(last_hc, c + 1);
		// phase-correct: extremes and a random compare, both polarities
		for (int i = 0; i < 6; i++) begin
			c = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 255 : 2 + $urandom % 252;
			com = (i < 3) ? COM_CLEAR : COM_SET;
			axi_wr(OFS_COMPARE, 8'(c));
			axi_wr(OFS_CONTROL_A, ctl(WM_PHASE, com, CS_DIV1, 1'b0));
			wait_flag(1'b0);
			span(1'b0);
			check(last_gap, 510);
			e = (i < 3) ? 2 * c : 510 - 2 * c;
			tol = (c == 0 || c == 255) ? 0 : 1;
			check(last_hc >= e - tol && last_hc <= e + tol, 1'b1);
		end
		tally_and_finish;
	end
endmodule // tb_twm_top

// >>> tb/twm_load.sv
// load model hanging on the compare output pin
`timescale 1ns/100ps
module twm_load (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// pin and measurement window
	input  wire logic compare_output_pin,
	input  wire logic compare_output_oe,
	input  wire logic window_clr,
	output int        high_cnt
);
	logic level;

	// a released pin falls to the pull-down, so no stale level is seen
	assign level = compare_output_oe ? compare_output_pin : 1'b0;

	// high time; a clear counts its own cycle so windows join up
	always_ff @(posedge aclk) begin
		if (!aresetn)
			high_cnt <= 0;
		else if (window_clr)
			high_cnt <= int'(level);
		else
			high_cnt <= high_cnt + int'(level);
	end
endmodule // twm_load

// >>> verilog/twm_pkg.sv
// constants, register map and field layout of the waveform timer
package twm_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the bus
	localparam logic [7:0] OFS_CONTROL_A  = 8'h00;
	localparam logic [7:0] OFS_COUNTER    = 8'h04;
	localparam logic [7:0] OFS_COMPARE    = 8'h08;
	localparam logic [7:0] OFS_FLAGS      = 8'h0C;
	localparam logic [7:0] OFS_DIRECTION  = 8'h10;

	// values after reset
	localparam logic [7:0] RST_CONTROL_A  = 8'h00;
	localparam logic [7:0] RST_COUNTER    = 8'h00;
	localparam logic [7:0] RST_COMPARE    = 8'h00;

	// counter extremes
	localparam logic [7:0] CNT_BOTTOM     = 8'h00;
	localparam logic [7:0] CNT_MAX        = 8'hFF;

	// control register field positions
	localparam int POS_FORCE   = 7;
	localparam int POS_WGM_LO  = 6;
	localparam int POS_WGM_HI  = 3;

	// flag register bit positions
	localparam int POS_OVF     = 0;
	localparam int POS_CMP     = 1;

	// prescaler tap masks: a tick when the low bits are all ones
	localparam int PRE_W = 10;
	localparam logic [9:0] MASK_DIV8    = 10'h007;
	localparam logic [9:0] MASK_DIV64   = 10'h03F;
	localparam logic [9:0] MASK_DIV256  = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// waveform modes, clock selects and output modes
	typedef enum logic [1:0] {
		WM_NORMAL, WM_PHASE, WM_CLEAR, WM_FAST
	} twm_mode_t;
	localparam logic [2:0] CS_STOP = 3'b000;
	localparam logic [2:0] CS_DIV1 = 3'b001;
	localparam logic [2:0] CS_DIV8 = 3'b010;
	localparam logic [2:0] CS_DIV64 = 3'b011;
	localparam logic [2:0] CS_DIV256 = 3'b100;
	localparam logic [2:0] CS_DIV1024 = 3'b101;
	localparam logic [2:0] CS_EXT_FALL = 3'b110;
	localparam logic [2:0] CS_EXT_RISE = 3'b111;
	localparam logic [1:0] COM_OFF = 2'b00;
	localparam logic [1:0] COM_TOGGLE = 2'b01;
	localparam logic [1:0] COM_CLEAR = 2'b10;
	localparam logic [1:0] COM_SET = 2'b11;

	// control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       force_compare_strobe;
		logic       waveform_mode_lo;
		logic [1:0] compare_output_mode;
		logic       waveform_mode_hi;
		logic [2:0] clock_select;
	} twm_ctrl_t;

endpackage

// >>> verilog/twm_top.sv
// 8-bit timer with one compare output, four waveform modes, AXI4-Lite regs
//
// Behaviour
// R1: fast PWM with toggle mode inverts the output on every compare match.
// R2: PWM modes load compare value at TOP; other modes use it at once.
// R3: waveform mode 1 counts up to MAX then down to BOTTOM, repeating.
// R4: phase-correct is 8-bit, reverses at MAX, stays at MAX one tick.
// R5: non-inverting clears on up-count match, sets on down; inverting reverse.
// R6: output mode two is non-inverted, three is inverted phase-correct PWM.
// R7: phase-correct sets the overflow flag each time the counter hits BOTTOM.
// R8: a phase-correct period is 510 ticks from the selected prescale tap.
// R9: compare at BOTTOM gives constant low, at MAX constant high (non-inv).
// R10: output changes at BOTTOM without a match to keep symmetry.
// R11: everything on one clock; the tick is only a clock enable.
// R12: force strobe applies the output action at once in non-PWM modes only.
// R13: force strobe reads zero; software writes zero to it in PWM modes.
// R14: mode field in bits 6 and 3; TOP and overflow point per mode.
// R15: the output reaches the pin only when its direction is output.
// R16: control register resets to zero: normal mode, stopped, disconnected.
// R17: clock select picks stop, five prescale taps or external edges.
// R18: non-PWM output modes: off, toggle, clear, set on match.
// R19: writing the counter suppresses the compare match on the next tick.
// R20: both flags clear by vector acknowledge or by writing a one.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module twm_top (
	// clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write address and data
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// external count input and flag handshakes
	input  wire logic        external_count_input,
	input  wire logic        overflow_ack,
	input  wire logic        compare_ack,
	output logic             overflow_flag,
	output logic             compare_match_flag,
	// compare output pin
	output logic             compare_output_pin,
	output logic             compare_output_oe
);
	import twm_pkg::*;

	twm_ctrl_t   ctrl;
	logic [7:0]  counter_value;
	logic [7:0]  compare_value;
	logic [7:0]  compare_buf;
	logic        pin_direction;
	logic        count_up;
	logic        wave;
	logic        match_block;
	logic [PRE_W-1:0] prescale;
	logic        ext_prev;
	logic        aw_held, w_held;
	logic [7:0]  aw_addr_q;
	logic [7:0]  w_data_q;
	logic        w_lane_q;

	////////////////////////////////////////////////////////////////////////
	// decoding shared by several processes
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == OFS_CONTROL_A) || (a == OFS_COUNTER) ||
			(a == OFS_COMPARE) || (a == OFS_FLAGS) ||
			(a == OFS_DIRECTION);
	endfunction

	function automatic logic tap(input logic [PRE_W-1:0] p,
		input logic [PRE_W-1:0] m);
		tap = ((p & m) == m);
	endfunction

	// level after a non-pwm compare event, match or forced
	function automatic logic com_action(input logic [1:0] cm,
		input logic w);
		case (cm)
			COM_TOGGLE: com_action = !w;
			COM_CLEAR:  com_action = 1'b0;
			COM_SET:    com_action = 1'b1;
			default:    com_action = w;
		endcase
	endfunction

	twm_mode_t mode;
	logic      pwm;
	logic      tick;
	logic      wr_fire;
	logic      wr_ok;
	logic [7:0] ocr;
	logic      match;
	logic      at_top;
	logic      force_now;
	twm_ctrl_t wr_ctrl;
	logic      next_wave;
	logic      inv;

	// mode field is split over bits 6 and 3, high bit at 3
	assign mode = twm_mode_t'({ctrl.waveform_mode_hi,
		ctrl.waveform_mode_lo}); // see R14
	assign pwm  = (mode == WM_PHASE) || (mode == WM_FAST);
	assign inv  = ctrl.compare_output_mode[0];
	// pwm modes compare against the buffered copy
	assign ocr  = pwm ? compare_buf : compare_value; // see R2

	// tick source; the tick only enables, never clocks
	always_comb begin // see R11 // see R17
		case (ctrl.clock_select)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = tap(prescale, MASK_DIV8);
			CS_DIV64:    tick = tap(prescale, MASK_DIV64);
			CS_DIV256:   tick = tap(prescale, MASK_DIV256);
			CS_DIV1024:  tick = tap(prescale, MASK_DIV1024);
			CS_EXT_FALL: tick = ext_prev && !external_count_input;
			CS_EXT_RISE: tick = !ext_prev && external_count_input;
			default:     tick = 1'b0;
		endcase
	end

	assign wr_fire = aw_held && w_held && !bvalid;
	assign wr_ok   = wr_fire && w_lane_q;
	assign match   = tick && !match_block && (counter_value == ocr);
	assign at_top  = tick && (counter_value == CNT_MAX);
	// strobe and the modes it acts in arrive in the same write
	assign wr_ctrl   = twm_ctrl_t'(w_data_q);
	assign force_now = wr_ok && (aw_addr_q == OFS_CONTROL_A) &&
		w_data_q[POS_FORCE] && !wr_ctrl.waveform_mode_lo; // see R12

	////////////////////////////////////////////////////////////////////////
	// prescaler and external edge sampler, free running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescale <= '0;
			ext_prev <= 1'b0;
		end else if (ce) begin
			prescale <= prescale + 1'b1;
			ext_prev <= external_count_input;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write channels: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_lane_q <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			awready <= 1'b0;
			wready <= 1'b0;
		end else if (ce) begin
			awready <= !aw_held && !(awvalid && awready);
			wready <= !w_held && !(wvalid && wready);
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data_q <= wdata[7:0];
				w_lane_q <= wstrb[0];
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= reg_hit(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// control and direction registers; strobe bit is never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= twm_ctrl_t'(RST_CONTROL_A); // see R16
			pin_direction <= 1'b0;
		end else if (ce && wr_ok) begin
			if (aw_addr_q == OFS_CONTROL_A)
				ctrl <= twm_ctrl_t'({1'b0, w_data_q[6:0]}); // see R13
			if (aw_addr_q == OFS_DIRECTION)
				pin_direction <= w_data_q[0];
		end
	end

	// compare value and its top-loaded buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_value <= RST_COMPARE;
			compare_buf <= RST_COMPARE;
		end else if (ce) begin
			if (wr_ok && aw_addr_q == OFS_COMPARE)
				compare_value <= w_data_q;
			if (!pwm || at_top)
				compare_buf <= compare_value; // see R2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter sequencing per mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_value <= RST_COUNTER;
			count_up <= 1'b1;
			match_block <= 1'b0;
		end else if (ce) begin
			if (wr_ok && aw_addr_q == OFS_COUNTER) begin
				counter_value <= w_data_q;
				match_block <= 1'b1; // see R19
			end else if (tick) begin
				match_block <= 1'b0;
				case (mode)
					WM_PHASE: begin // see R3 // see R4 // see R8
						if (count_up && counter_value == CNT_MAX) begin
							count_up <= 1'b0;
							counter_value <= counter_value - 1'b1;
						end else if (!count_up &&
							counter_value == CNT_BOTTOM) begin
							count_up <= 1'b1;
							counter_value <= counter_value + 1'b1;
						end else if (count_up)
							counter_value <= counter_value + 1'b1;
						else
							counter_value <= counter_value - 1'b1;
					end
					WM_CLEAR: begin
						count_up <= 1'b1;
						counter_value <= match ? CNT_BOTTOM :
							counter_value + 1'b1; // see R14
					end
					default: begin
						count_up <= 1'b1;
						counter_value <= counter_value + 1'b1;
					end
				endcase
			end
		end
	end

	// flags: a hardware set beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_flag <= 1'b0;
			compare_match_flag <= 1'b0;
		end else if (ce) begin
			if ((mode == WM_PHASE) ? (tick && !count_up &&
				counter_value == CNT_BOTTOM) : at_top)
				overflow_flag <= 1'b1; // see R7 // see R14
			else if (overflow_ack || (wr_ok && aw_addr_q == OFS_FLAGS &&
				w_data_q[POS_OVF]))
				overflow_flag <= 1'b0; // see R20
			if (match)
				compare_match_flag <= 1'b1;
			else if (compare_ack || (wr_ok && aw_addr_q == OFS_FLAGS &&
				w_data_q[POS_CMP]))
				compare_match_flag <= 1'b0; // see R20
		end
	end

	////////////////////////////////////////////////////////////////////////
	// waveform level
	always_comb begin
		next_wave = wave;
		case (mode)
			WM_FAST: begin
				if (ctrl.compare_output_mode == COM_TOGGLE) begin
					if (match)
						next_wave = !wave; // see R1
				end else if (ctrl.compare_output_mode[1]) begin
					// compare at top: match ignored, top action only
					if (at_top)
						next_wave = !inv;
					else if (match && ocr != CNT_MAX)
						next_wave = inv;
				end
			end
			WM_PHASE: begin
				if (ctrl.compare_output_mode[1]) begin // see R6
					// bottom restores the pre-up-match level
					if (tick && !count_up && counter_value == CNT_BOTTOM)
						next_wave = (ocr != CNT_BOTTOM) ^ inv; // see R10
					else if (match && ocr != CNT_MAX &&
						ocr != CNT_BOTTOM)
						next_wave = count_up ? inv : !inv; // see R5
					else if (ocr == CNT_MAX && at_top)
						next_wave = !inv; // see R9
				end
			end
			default: begin
				if (match) // see R18
					next_wave = com_action(ctrl.compare_output_mode,
						wave);
			end
		endcase
		// a forced compare uses the output mode written with it
		if (force_now) // see R12
			next_wave = com_action(wr_ctrl.compare_output_mode, wave);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wave <= 1'b0;
			compare_output_pin <= 1'b0;
			compare_output_oe <= 1'b0;
		end else if (ce) begin
			wave <= next_wave;
			compare_output_pin <= next_wave;
			// reserved pwm code 01 in phase mode leaves pin to port
			compare_output_oe <= pin_direction &&
				(ctrl.compare_output_mode != COM_OFF) &&
				!(mode == WM_PHASE &&
				ctrl.compare_output_mode == COM_TOGGLE); // see R15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (ce) begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rresp <= reg_hit(araddr) ? RESP_OKAY : RESP_DECERR;
				case ({araddr[7:2], 2'b00})
					OFS_CONTROL_A:
						rdata <= {24'h00_0000, 1'b0,
							ctrl[6:0]}; // see R13
					OFS_COUNTER:   rdata <= {24'h00_0000, counter_value};
					OFS_COMPARE:   rdata <= {24'h00_0000, compare_value};
					OFS_FLAGS:     rdata <= {30'h0000_0000,
						compare_match_flag, overflow_flag};
					OFS_DIRECTION: rdata <= {31'h0000_0000, pin_direction};
					default:       rdata <= 32'h0000_0000;
				endcase
			end else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_pc_max_turn: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && tick && mode == WM_PHASE && count_up &&
		counter_value == CNT_MAX && !wr_ok |=>
		counter_value == 8'hFE && !count_up) // see R4
		else $error("phase mode did not turn at max");
	a_pc_bottom_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && tick && mode == WM_PHASE && !count_up &&
		counter_value == CNT_BOTTOM && !wr_ok |=>
		overflow_flag && count_up) // see R7
		else $error("no overflow at bottom in phase mode");
	a_normal_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && at_top && mode == WM_NORMAL && !wr_ok |=>
		counter_value == CNT_BOTTOM && overflow_flag) // see R14
		else $error("normal mode wrap or flag wrong");
	a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && match && mode == WM_CLEAR && !wr_ok |=>
		counter_value == CNT_BOTTOM && compare_match_flag) // see R14
		else $error("clear mode did not clear on match");
	a_fast_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && match && mode == WM_FAST &&
		ctrl.compare_output_mode == COM_TOGGLE |=>
		wave != $past(wave)) // see R1
		else $error("fast toggle missed");
	a_pc_up_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && match && mode == WM_PHASE && count_up &&
		ctrl.compare_output_mode == COM_CLEAR && ocr != CNT_MAX &&
		ocr != CNT_BOTTOM |=> !wave && !compare_output_pin) // see R5
		else $error("up-count match did not clear");
	a_force_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && force_now && !tick &&
		wr_ctrl.compare_output_mode == COM_SET |=>
		wave && $stable(counter_value)) // see R12
		else $error("forced set not applied");
	a_write_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && wr_ok && aw_addr_q == OFS_COUNTER |=>
		match_block) // see R19
		else $error("counter write did not block match");
	a_ctrl_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid |-> rdata[POS_FORCE] == 1'b0 ||
		$past(araddr) != OFS_CONTROL_A) // see R13
		else $error("strobe read back as one");
	a_pin_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !pin_direction |=> !compare_output_oe) // see R15
		else $error("pin driven without direction");

	c_pc_period: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == WM_PHASE && tick && !count_up &&
		counter_value == CNT_BOTTOM);
	c_fast_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == WM_FAST && match && ctrl.compare_output_mode == COM_TOGGLE);
	c_force: cover property (@(posedge aclk) disable iff (!aresetn)
		force_now);
	c_ctc_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == WM_CLEAR && match);

endmodule // twm_top
